// ### core/pioc_port_ctrl.sv
// Per-port interrupt status, interrupt mask and operation control registers
`timescale 1ns/1ps
module pioc_port_ctrl
	import pioc_pkg::*;
#(
	parameter int PORT_NUM = 1,
	parameter bit HAS_PHY = 1'b1,
	parameter int PHY_SRC_W = 8,
	parameter int DATA_W = 8
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [PIOC_ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [PHY_SRC_W-1:0] phy_irq_src,
	input wire logic acl_cnt_event,
	output logic port_irq,
	output logic tail_tag_en,
	output logic [1:0] queue_mode,
	input wire logic [DATA_W-1:0] fab_egr_data,
	input wire logic fab_egr_valid,
	input wire logic [DATA_W-1:0] line_rx_data,
	input wire logic line_rx_valid,
	output logic [DATA_W-1:0] fab_ing_data,
	output logic fab_ing_valid,
	output logic [DATA_W-1:0] line_tx_data,
	output logic line_tx_valid
);
	logic [1:0] status_q, status_d;
	logic [1:0] mask_q, mask_d;
	logic [7:0] op_ctrl_q, op_ctrl_d;
	logic [7:0] rdata_q, rdata_d;
	logic wr_status, wr_mask, wr_ctrl;
	logic acl_toggle;
	logic [1:0] pending;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Writes to the status register are accepted and have no effect
	assign wr_status = reg_wr && reg_addr == PIOC_OFS_IRQ_STATUS;
	assign wr_mask = reg_wr && reg_addr == PIOC_OFS_IRQ_MASK;
	assign wr_ctrl = reg_wr && reg_addr == PIOC_OFS_OP_CTRL;
	assign acl_toggle = wr_mask && (reg_wdata[PIOC_BIT_ACL] != mask_q[PIOC_BIT_ACL]);

	// ----------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------
	// Next values for status and mask
	always_comb begin
		status_d = status_q;
		mask_d = mask_q;
		status_d[PIOC_BIT_PHY] = HAS_PHY && (|phy_irq_src);
		if (acl_toggle) begin
			status_d[PIOC_BIT_ACL] = 1'b0;
		end
		if (acl_cnt_event) begin
			status_d[PIOC_BIT_ACL] = 1'b1;
		end
		if (wr_mask) begin
			mask_d = reg_wdata[1:0];
		end
	end

	// Register status and mask
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			status_q <= PIOC_STATUS_RST;
			mask_q <= PIOC_MASK_RST;
		end else begin
			status_q <= status_d;
			mask_q <= mask_d;
		end
	end

	// PHY status bit raises the interrupt only on PHY ports
	assign pending = status_q & ~mask_q & {HAS_PHY, 1'b1};
	assign port_irq = |pending;

	// ----------------------------------------------------------------
	// Operation control
	// ----------------------------------------------------------------
	// Next value of the control register
	always_comb begin
		op_ctrl_d = op_ctrl_q;
		if (wr_ctrl) begin
			op_ctrl_d[PIOC_BIT_LOCAL_LOOP] = reg_wdata[PIOC_BIT_LOCAL_LOOP];
			op_ctrl_d[PIOC_BIT_REMOTE_LOOP] = reg_wdata[PIOC_BIT_REMOTE_LOOP];
			op_ctrl_d[PIOC_BIT_TAIL_TAG] = reg_wdata[PIOC_BIT_TAIL_TAG];
			if (reg_wdata[1:0] != PIOC_Q_RESERVED) begin
				op_ctrl_d[1:0] = reg_wdata[1:0];
			end
		end
		op_ctrl_d[5:3] = 3'h0;
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			op_ctrl_q <= PIOC_OP_CTRL_RST;
		end else begin
			op_ctrl_q <= op_ctrl_d;
		end
	end

	assign tail_tag_en = op_ctrl_q[PIOC_BIT_TAIL_TAG];
	assign queue_mode = op_ctrl_q[1:0];

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Read data, one cycle after the read strobe; no read side effects
	always_comb begin
		rdata_d = rdata_q;
		if (reg_rd) begin
			case (reg_addr)
				PIOC_OFS_IRQ_STATUS: rdata_d = {6'h00, status_q};
				PIOC_OFS_IRQ_MASK: rdata_d = {6'h00, mask_q};
				PIOC_OFS_OP_CTRL: rdata_d = op_ctrl_q;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// Register the read data
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= PIOC_RDATA_RST;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// ----------------------------------------------------------------
	// Loopback datapath
	// ----------------------------------------------------------------
	// echo paths for both port kinds
	pioc_loop_mux #(
		.DATA_W(DATA_W)
	) u_loop (
		.core_clk(core_clk),
		.resetn(resetn),
		.local_loop_en(op_ctrl_q[PIOC_BIT_LOCAL_LOOP]),
		.remote_loop_en(op_ctrl_q[PIOC_BIT_REMOTE_LOOP]),
		.fab_egr_data(fab_egr_data),
		.fab_egr_valid(fab_egr_valid),
		.line_rx_data(line_rx_data),
		.line_rx_valid(line_rx_valid),
		.fab_ing_data(fab_ing_data),
		.fab_ing_valid(fab_ing_valid),
		.line_tx_data(line_tx_data),
		.line_tx_valid(line_tx_valid)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	property p_phy_status;
		##1 status_q[PIOC_BIT_PHY] == (HAS_PHY && |$past(phy_irq_src));
	endproperty
	a_phy_status: assert property (p_phy_status) else $error("phy status wrong");

	property p_acl_set;
		acl_cnt_event |=> status_q[PIOC_BIT_ACL];
	endproperty
	a_acl_set: assert property (p_acl_set) else $error("acl status not set");

	property p_acl_sticky;
		status_q[PIOC_BIT_ACL] && !acl_toggle |=> status_q[PIOC_BIT_ACL];
	endproperty
	a_acl_sticky: assert property (p_acl_sticky) else $error("acl status lost");

	property p_acl_clear;
		acl_toggle && !acl_cnt_event |=> !status_q[PIOC_BIT_ACL];
	endproperty
	a_acl_clear: assert property (p_acl_clear) else $error("acl toggle no clear");

	property p_status_ro;
		wr_status && !acl_cnt_event |=> status_q[PIOC_BIT_ACL] == $past(status_q[PIOC_BIT_ACL]);
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status write changed acl");

	property p_irq_acl;
		status_q[PIOC_BIT_ACL] && !mask_q[PIOC_BIT_ACL] |-> port_irq;
	endproperty
	a_irq_acl: assert property (p_irq_acl) else $error("acl irq missing");

	property p_irq_masked;
		(mask_q == 2'h3) |-> !port_irq;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("masked irq raised");

	property p_irq_cause;
		port_irq |-> (status_q[PIOC_BIT_ACL] && !mask_q[PIOC_BIT_ACL]) ||
			(HAS_PHY && status_q[PIOC_BIT_PHY] && !mask_q[PIOC_BIT_PHY]);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");

	property p_rd_upper;
		reg_rd && reg_addr != PIOC_OFS_OP_CTRL |=> reg_rdata[7:2] == 6'h00;
	endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("reserved bits set");

	property p_queue_legal;
		queue_mode != PIOC_Q_RESERVED && op_ctrl_q[5:3] == 3'h0;
	endproperty
	a_queue_legal: assert property (p_queue_legal) else $error("illegal control");

	property p_ctrl_write;
		wr_ctrl && reg_wdata[1:0] != PIOC_Q_RESERVED |=> op_ctrl_q == ($past(reg_wdata) & 8'hC7);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

	c_acl_irq: cover property (acl_cnt_event ##1 port_irq ##[1:20] acl_toggle);
	c_phy_irq: cover property (status_q[PIOC_BIT_PHY] && port_irq);
	c_remote: cover property (op_ctrl_q[PIOC_BIT_REMOTE_LOOP] && line_tx_valid);
	c_four_q: cover property (queue_mode == PIOC_Q_FOUR);
endmodule // pioc_port_ctrl

// ### shared/pioc_pkg.sv
// Constants for the per-port interrupt and operation control register group
package pioc_pkg;
	// ----------------------------------------------------------------
	// Register offsets within one port block
	// ----------------------------------------------------------------
	localparam int PIOC_ADDR_W = 12;
	localparam logic [11:0] PIOC_OFS_IRQ_STATUS = 12'h01B;
	localparam logic [11:0] PIOC_OFS_IRQ_MASK = 12'h01F;
	localparam logic [11:0] PIOC_OFS_OP_CTRL = 12'h020;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int PIOC_BIT_ACL = 0;
	localparam int PIOC_BIT_PHY = 1;
	localparam int PIOC_BIT_TAIL_TAG = 2;
	localparam int PIOC_BIT_REMOTE_LOOP = 6;
	localparam int PIOC_BIT_LOCAL_LOOP = 7;
	localparam int PIOC_QUEUE_LSB = 0;

	// ----------------------------------------------------------------
	// Reset values and encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] PIOC_STATUS_RST = 2'h0;
	localparam logic [1:0] PIOC_MASK_RST = 2'h0;
	localparam logic [7:0] PIOC_OP_CTRL_RST = 8'h00;
	localparam logic [7:0] PIOC_RDATA_RST = 8'h00;

	typedef enum logic [1:0] {
		PIOC_Q_SINGLE = 2'b00,
		PIOC_Q_TWO = 2'b01,
		PIOC_Q_FOUR = 2'b10,
		PIOC_Q_RESERVED = 2'b11
	} pioc_queue_mode_t;
endpackage

// ### core/pioc_loop_mux.sv
// Loopback steering between switch fabric and the port's external pins
`timescale 1ns/1ps
module pioc_loop_mux
	import pioc_pkg::*;
#(
	parameter int DATA_W = 8
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic local_loop_en,
	input wire logic remote_loop_en,
	input wire logic [DATA_W-1:0] fab_egr_data,
	input wire logic fab_egr_valid,
	input wire logic [DATA_W-1:0] line_rx_data,
	input wire logic line_rx_valid,
	output logic [DATA_W-1:0] fab_ing_data,
	output logic fab_ing_valid,
	output logic [DATA_W-1:0] line_tx_data,
	output logic line_tx_valid
);
	logic [DATA_W-1:0] fab_ing_data_d;
	logic fab_ing_valid_d;
	logic [DATA_W-1:0] line_tx_data_d;
	logic line_tx_valid_d;

	// ----------------------------------------------------------------
	// Path selection
	// ----------------------------------------------------------------
	// Steer each direction by the two loopback controls
	always_comb begin
		if (local_loop_en) begin
			fab_ing_data_d = fab_egr_data;
			fab_ing_valid_d = fab_egr_valid;
		end else if (remote_loop_en) begin
			fab_ing_data_d = '0;
			fab_ing_valid_d = 1'b0;
		end else begin
			fab_ing_data_d = line_rx_data;
			fab_ing_valid_d = line_rx_valid;
		end
		if (remote_loop_en) begin
			line_tx_data_d = line_rx_data;
			line_tx_valid_d = line_rx_valid;
		end else if (local_loop_en) begin
			line_tx_data_d = '0;
			line_tx_valid_d = 1'b0;
		end else begin
			line_tx_data_d = fab_egr_data;
			line_tx_valid_d = fab_egr_valid;
		end
	end

	// Register both outputs
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			fab_ing_data <= '0;
			fab_ing_valid <= 1'b0;
			line_tx_data <= '0;
			line_tx_valid <= 1'b0;
		end else begin
			fab_ing_data <= fab_ing_data_d;
			fab_ing_valid <= fab_ing_valid_d;
			line_tx_data <= line_tx_data_d;
			line_tx_valid <= line_tx_valid_d;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_remote_echo;
		@(posedge core_clk) disable iff (!resetn)
		remote_loop_en && line_rx_valid |=> line_tx_valid && line_tx_data == $past(line_rx_data);
	endproperty
	a_remote_echo: assert property (p_remote_echo) else $error("remote echo missing");

	property p_local_return;
		@(posedge core_clk) disable iff (!resetn)
		local_loop_en && fab_egr_valid |=> fab_ing_valid && fab_ing_data == $past(fab_egr_data);
	endproperty
	a_local_return: assert property (p_local_return) else $error("local return missing");

	property p_remote_bypass;
		@(posedge core_clk) disable iff (!resetn)
		remote_loop_en && !local_loop_en |=> !fab_ing_valid;
	endproperty
	a_remote_bypass: assert property (p_remote_bypass) else $error("fabric fed in remote");
endmodule // pioc_loop_mux

// ### verif/port_irq_and_operation_control_tb.sv
// Self-checking bench for the per-port interrupt and operation control registers
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module port_irq_and_operation_control_tb
	import pioc_pkg::*;
;
	logic core_clk, resetn, reg_wr, reg_rd, acl_cnt_event, fab_egr_valid, line_rx_valid;
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rdata_m, fab_egr_data, line_rx_data, phy_irq_src;
	logic [7:0] fab_ing_data, line_tx_data;
	logic port_irq, irq_m, tag_m, tail_tag_en, fab_ing_valid, line_tx_valid;
	logic [1:0] queue_mode;
	int num_errors, comparisons;

	// ----------------------------------------------------------------
	// PHY port and MAC-only port on one register bus
	// ----------------------------------------------------------------
	pioc_port_ctrl #(.PORT_NUM(1), .HAS_PHY(1'b1)) dut_u (.core_clk, .resetn, .reg_addr,
		.reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .phy_irq_src, .acl_cnt_event, .port_irq,
		.tail_tag_en, .queue_mode, .fab_egr_data, .fab_egr_valid, .line_rx_data,
		.line_rx_valid, .fab_ing_data, .fab_ing_valid, .line_tx_data, .line_tx_valid);
	// MAC port never sees control writes, so only one port carries tail tags
	pioc_port_ctrl #(.PORT_NUM(6), .HAS_PHY(1'b0)) mac_u (.core_clk, .resetn, .reg_addr,
		.reg_wr(reg_wr && reg_addr != PIOC_OFS_OP_CTRL), .reg_rd, .reg_wdata,
		.reg_rdata(rdata_m), .phy_irq_src, .acl_cnt_event,
		.port_irq(irq_m), .tail_tag_en(tag_m), .queue_mode(), .fab_egr_data, .fab_egr_valid,
		.line_rx_data, .line_rx_valid, .fab_ing_data(), .fab_ing_valid(), .line_tx_data(),
		.line_tx_valid());

	// Free-running core clock, 4 ns period
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	// One-cycle write strobe
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask

	// One-cycle read strobe, data checked the cycle after
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		`CHK(reg_rdata, e)
	endtask

	// Single-cycle counter event
	task automatic acl_pulse();
		@(negedge core_clk);
		acl_cnt_event = 1'b1;
		@(negedge core_clk);
		acl_cnt_event = 1'b0;
	endtask

	// Verdict and end of run
	task automatic wrap_up();
		if (num_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Watchdog against a hung run
	initial begin
		#20000;
		num_errors++;
		wrap_up();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		num_errors = 0;
		comparisons = 0;
		resetn = 1'b0;
		{reg_wr, reg_rd, acl_cnt_event, fab_egr_valid, line_rx_valid} = 5'h00;
		reg_addr = 12'h000;
		reg_wdata = 8'h00;
		phy_irq_src = 8'h00;
		fab_egr_data = 8'hA5;
		line_rx_data = 8'h3C;
		repeat (3) @(negedge core_clk);
		resetn = 1'b1;
		// Reset values, reserved bits, unmapped offset
		`CHK(port_irq, 1'b0)
		`CHK(tail_tag_en, 1'b0)
		`CHK(queue_mode, PIOC_Q_SINGLE)
		rd(PIOC_OFS_IRQ_STATUS, 8'h00);
		rd(PIOC_OFS_IRQ_MASK, 8'h00);
		rd(PIOC_OFS_OP_CTRL, 8'h00);
		rd(12'h021, 8'h00);
		wr(PIOC_OFS_OP_CTRL, 8'hFE);
		rd(PIOC_OFS_OP_CTRL, 8'hC6);
		`CHK(tail_tag_en, 1'b1)
		`CHK(tag_m, 1'b0)
		// Every queue code, then the reserved one
		for (int q = 0; q < 3; q++) begin
			wr(PIOC_OFS_OP_CTRL, {6'h00, q[1:0]});
			rd(PIOC_OFS_OP_CTRL, {6'h00, q[1:0]});
			`CHK(queue_mode, q[1:0])
		end
		wr(PIOC_OFS_OP_CTRL, 8'h07);
		rd(PIOC_OFS_OP_CTRL, 8'h06);
		`CHK(queue_mode, PIOC_Q_FOUR)
		wr(PIOC_OFS_OP_CTRL, 8'h00);
		// Counter event: sticky until mask bit toggles
		acl_pulse();
		`CHK(port_irq, 1'b1)
		`CHK(irq_m, 1'b1)
		rd(PIOC_OFS_IRQ_STATUS, 8'h01);
		rd(PIOC_OFS_IRQ_STATUS, 8'h01);
		wr(PIOC_OFS_IRQ_STATUS, 8'hFF);
		rd(PIOC_OFS_IRQ_STATUS, 8'h01);
		wr(PIOC_OFS_IRQ_MASK, 8'h01);
		rd(PIOC_OFS_IRQ_STATUS, 8'h00);
		acl_pulse();
		`CHK(port_irq, 1'b0)
		rd(PIOC_OFS_IRQ_STATUS, 8'h01);
		wr(PIOC_OFS_IRQ_MASK, 8'h01);
		rd(PIOC_OFS_IRQ_STATUS, 8'h01);
		wr(PIOC_OFS_IRQ_MASK, 8'h00);
		rd(PIOC_OFS_IRQ_STATUS, 8'h00);
		// PHY sources: PHY port only, maskable, OR of sources
		@(negedge core_clk);
		phy_irq_src = 8'h81;
		@(negedge core_clk);
		`CHK(port_irq, 1'b1)
		`CHK(irq_m, 1'b0)
		rd(PIOC_OFS_IRQ_STATUS, 8'h02);
		`CHK(rdata_m, 8'h00)
		wr(PIOC_OFS_IRQ_MASK, 8'hFF);
		rd(PIOC_OFS_IRQ_MASK, 8'h03);
		`CHK(port_irq, 1'b0)
		phy_irq_src = 8'h01;
		rd(PIOC_OFS_IRQ_STATUS, 8'h02);
		phy_irq_src = 8'h00;
		@(negedge core_clk);
		rd(PIOC_OFS_IRQ_STATUS, 8'h00);
		wr(PIOC_OFS_IRQ_MASK, 8'h00);
		// Loopback table: bit 1 of m is local, bit 0 remote
		for (int m = 0; m < 4; m++) begin
			wr(PIOC_OFS_OP_CTRL, {m[1:0], 6'h00});
			@(negedge core_clk);
			fab_egr_valid = 1'b1;
			line_rx_valid = 1'b1;
			@(negedge core_clk);
			fab_egr_valid = 1'b0;
			line_rx_valid = 1'b0;
			`CHK(line_tx_valid, (m != 2))
			`CHK(fab_ing_valid, (m != 1))
			if (m != 2) `CHK(line_tx_data, (m[0] ? 8'h3C : 8'hA5))
			if (m != 1) `CHK(fab_ing_data, (m[1] ? 8'hA5 : 8'h3C))
		end
		wrap_up();
	end
endmodule // port_irq_and_operation_control_tb
